//--- pkg/jtc_pkg.sv
// package for the test access port controller: codes, widths, fixed values, tap states
package jtc_pkg;

	// ----------------------------------------------------------------
	// chain widths
	// ----------------------------------------------------------------
	localparam int IR_W  = 4;
	localparam int DR_W  = 32;
	localparam int BSC_W = 8;

	// ----------------------------------------------------------------
	// instruction codes and fixed values
	// ----------------------------------------------------------------
	localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
	localparam logic [IR_W-1:0] IR_INTEST  = 4'h1;
	localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h2;
	localparam logic [IR_W-1:0] IR_CORE_AB = 4'h8;
	localparam logic [IR_W-1:0] IR_CORE_DP = 4'ha;
	localparam logic [IR_W-1:0] IR_CORE_AP = 4'hb;
	localparam logic [IR_W-1:0] IR_IDCODE  = 4'he;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;         // pattern loaded in capture-ir
	localparam logic [DR_W-1:0] ID_VALUE   = 32'h1234_5671; // arbitrary value, lsb must be 1
	localparam logic [2:0]      TMS_RESET_RUN = 3'h5;       // highs that always reach reset

	// ----------------------------------------------------------------
	// tap states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TS_RESET  = 4'h0,
		TS_IDLE   = 4'h1,
		TS_SEL_DR = 4'h2,
		TS_CAP_DR = 4'h3,
		TS_SH_DR  = 4'h4,
		TS_EX1_DR = 4'h5,
		TS_PA_DR  = 4'h6,
		TS_EX2_DR = 4'h7,
		TS_UP_DR  = 4'h8,
		TS_SEL_IR = 4'h9,
		TS_CAP_IR = 4'ha,
		TS_SH_IR  = 4'hb,
		TS_EX1_IR = 4'hc,
		TS_PA_IR  = 4'hd,
		TS_EX2_IR = 4'he,
		TS_UP_IR  = 4'hf
	} jtc_state_t;

	// data chain picked by the active instruction
	typedef enum logic [2:0] {
		CH_EXT  = 3'h0,
		CH_INT  = 3'h1,
		CH_SAMP = 3'h2,
		CH_ID   = 3'h3,
		CH_CORE = 3'h4,
		CH_BYP  = 3'h5
	} jtc_chain_t;

endpackage

//--- src/jtc_tap.sv
// test access port controller: tap state machine, instruction and data chains
`timescale 1ns/100ps
`default_nettype none

module jtc_tap (
	// clock, power-on reset, enable
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_ce,
	// test port pins
	input  wire logic                    i_trst_b,
	input  wire logic                    i_tck,
	input  wire logic                    i_tms,
	input  wire logic                    i_tdi,
	output logic                         o_tdo,
	output logic                         o_tdo_oe_b,
	// core debug tap, boundary data, active instruction and its decode flags
	input  wire logic                    i_core_tdo,
	input  wire logic [jtc_pkg::BSC_W-1:0] i_bsc_pins,
	output logic [jtc_pkg::BSC_W-1:0]    o_bsc_upd,
	output logic [jtc_pkg::IR_W-1:0]     o_ir,
	output logic                         o_core_sel,
	output logic                         o_extest,
	output logic                         o_intest
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                         tck_s1, tck_s2, tck_d;
		logic                         tms_s1, tms_s2;
		logic                         tdi_s1, tdi_s2;
		logic                         trst_s1, trst_s2;
		logic                         ctdo_s1, ctdo_s2;
		jtc_pkg::jtc_state_t          state;
		logic [jtc_pkg::IR_W-1:0]     ir_sh;
		logic [jtc_pkg::IR_W-1:0]     ir;
		logic [jtc_pkg::DR_W-1:0]     dr_sh;
		logic [jtc_pkg::BSC_W-1:0]    bsc_upd;
		logic                         tdo;
		logic                         tdo_oe_b;
		logic                         core, ext, intst;
		logic [2:0]                   tms_run;
	} jtc_st_t;

	// tck syncs start at the pull-up level, so leaving reset shows no false tck edge
	localparam jtc_st_t ST_RST = '{state: jtc_pkg::TS_RESET, ir: jtc_pkg::IR_IDCODE,
		tck_s1: 1'b1, tck_s2: 1'b1, tck_d: 1'b1, tdo_oe_b: 1'b1, default: '0};

	jtc_st_t q;
	jtc_st_t d;
	logic    rise;
	logic    fall;
	jtc_pkg::jtc_chain_t chain;

	// instruction decode; anything unlisted falls to bypass
	function automatic jtc_pkg::jtc_chain_t decode(input logic [jtc_pkg::IR_W-1:0] ir);
		case (ir)
			jtc_pkg::IR_EXTEST:  decode = jtc_pkg::CH_EXT;
			jtc_pkg::IR_INTEST:  decode = jtc_pkg::CH_INT;
			jtc_pkg::IR_SAMPLE:  decode = jtc_pkg::CH_SAMP;
			jtc_pkg::IR_IDCODE:  decode = jtc_pkg::CH_ID;
			jtc_pkg::IR_CORE_AB,
			jtc_pkg::IR_CORE_DP,
			jtc_pkg::IR_CORE_AP: decode = jtc_pkg::CH_CORE;
			default:             decode = jtc_pkg::CH_BYP;
		endcase
	endfunction

	// standard sixteen-state graph
	function automatic jtc_pkg::jtc_state_t next_state(input jtc_pkg::jtc_state_t s, input logic tms);
		case (s)
			jtc_pkg::TS_RESET:  next_state = tms ? jtc_pkg::TS_RESET  : jtc_pkg::TS_IDLE;
			jtc_pkg::TS_IDLE:   next_state = tms ? jtc_pkg::TS_SEL_DR : jtc_pkg::TS_IDLE;
			jtc_pkg::TS_SEL_DR: next_state = tms ? jtc_pkg::TS_SEL_IR : jtc_pkg::TS_CAP_DR;
			jtc_pkg::TS_CAP_DR: next_state = tms ? jtc_pkg::TS_EX1_DR : jtc_pkg::TS_SH_DR;
			jtc_pkg::TS_SH_DR:  next_state = tms ? jtc_pkg::TS_EX1_DR : jtc_pkg::TS_SH_DR;
			jtc_pkg::TS_EX1_DR: next_state = tms ? jtc_pkg::TS_UP_DR  : jtc_pkg::TS_PA_DR;
			jtc_pkg::TS_PA_DR:  next_state = tms ? jtc_pkg::TS_EX2_DR : jtc_pkg::TS_PA_DR;
			jtc_pkg::TS_EX2_DR: next_state = tms ? jtc_pkg::TS_UP_DR  : jtc_pkg::TS_SH_DR;
			jtc_pkg::TS_UP_DR:  next_state = tms ? jtc_pkg::TS_SEL_DR : jtc_pkg::TS_IDLE;
			jtc_pkg::TS_SEL_IR: next_state = tms ? jtc_pkg::TS_RESET  : jtc_pkg::TS_CAP_IR;
			jtc_pkg::TS_CAP_IR: next_state = tms ? jtc_pkg::TS_EX1_IR : jtc_pkg::TS_SH_IR;
			jtc_pkg::TS_SH_IR:  next_state = tms ? jtc_pkg::TS_EX1_IR : jtc_pkg::TS_SH_IR;
			jtc_pkg::TS_EX1_IR: next_state = tms ? jtc_pkg::TS_UP_IR  : jtc_pkg::TS_PA_IR;
			jtc_pkg::TS_PA_IR:  next_state = tms ? jtc_pkg::TS_EX2_IR : jtc_pkg::TS_PA_IR;
			jtc_pkg::TS_EX2_IR: next_state = tms ? jtc_pkg::TS_UP_IR  : jtc_pkg::TS_SH_IR;
			jtc_pkg::TS_UP_IR:  next_state = tms ? jtc_pkg::TS_SEL_DR : jtc_pkg::TS_IDLE;
			default:            next_state = jtc_pkg::TS_RESET;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	// edges come from the sampled clock; tms and tdi share its sync depth so they line up
	always_comb begin
		d         = q;
		d.tck_s1  = i_tck;
		d.tck_s2  = q.tck_s1;
		d.tck_d   = q.tck_s2;
		d.tms_s1  = i_tms;
		d.tms_s2  = q.tms_s1;
		d.tdi_s1  = i_tdi;
		d.tdi_s2  = q.tdi_s1;
		d.trst_s1 = i_trst_b;
		d.trst_s2 = q.trst_s1;
		d.ctdo_s1 = i_core_tdo;
		d.ctdo_s2 = q.ctdo_s1;
		rise      = q.tck_s2 & ~q.tck_d;
		fall      = ~q.tck_s2 & q.tck_d;
		chain     = decode(q.ir);

		// consecutive tms-high count, only read by the checks below
		if (rise) begin
			d.tms_run = !q.tms_s2 ? 3'h0 : (q.tms_run == 3'h7) ? q.tms_run : q.tms_run + 3'h1;
		end

		if (!q.trst_s2) begin
			d.state = jtc_pkg::TS_RESET;
		end else if (rise) begin
			d.state = next_state(q.state, q.tms_s2);
			// strobes act on the edge that leaves the capture/shift/update state
			case (q.state)
				jtc_pkg::TS_CAP_IR: d.ir_sh = jtc_pkg::IR_CAPTURE;
				jtc_pkg::TS_SH_IR:  d.ir_sh = {q.tdi_s2, q.ir_sh[jtc_pkg::IR_W-1:1]};
				jtc_pkg::TS_UP_IR:  d.ir = q.ir_sh;
				jtc_pkg::TS_CAP_DR: begin
					case (chain)
						jtc_pkg::CH_ID:   d.dr_sh = jtc_pkg::ID_VALUE;
						jtc_pkg::CH_SAMP: d.dr_sh = {{(jtc_pkg::DR_W-jtc_pkg::BSC_W){1'b0}}, i_bsc_pins};
						jtc_pkg::CH_BYP:  d.dr_sh = '0;
						default:          d.dr_sh = q.dr_sh;
					endcase
				end
				jtc_pkg::TS_SH_DR: begin
					case (chain)
						jtc_pkg::CH_ID:   d.dr_sh = {q.tdi_s2, q.dr_sh[jtc_pkg::DR_W-1:1]};
						jtc_pkg::CH_SAMP: d.dr_sh = {{(jtc_pkg::DR_W-jtc_pkg::BSC_W){1'b0}}, q.tdi_s2,
							q.dr_sh[jtc_pkg::BSC_W-1:1]};
						jtc_pkg::CH_BYP:  d.dr_sh = {{(jtc_pkg::DR_W-1){1'b0}}, q.tdi_s2};
						default:          d.dr_sh = q.dr_sh;
					endcase
				end
				jtc_pkg::TS_UP_DR: begin
					if (chain == jtc_pkg::CH_SAMP) begin
						d.bsc_upd = q.dr_sh[jtc_pkg::BSC_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// any way into reset leaves the id instruction active
		if (d.state == jtc_pkg::TS_RESET) begin
			d.ir = jtc_pkg::IR_IDCODE;
		end

		// serial output moves on falling edges so a following device sees a stable bit
		if (!q.trst_s2) begin
			d.tdo_oe_b = 1'b1;
		end else if (fall) begin
			if (q.state == jtc_pkg::TS_SH_IR) begin
				d.tdo      = q.ir_sh[0];
				d.tdo_oe_b = 1'b0;
			end else if (q.state == jtc_pkg::TS_SH_DR && chain != jtc_pkg::CH_EXT
				&& chain != jtc_pkg::CH_INT) begin
				d.tdo      = (chain == jtc_pkg::CH_CORE) ? q.ctdo_s2 : q.dr_sh[0];
				d.tdo_oe_b = 1'b0;
			end else begin
				d.tdo_oe_b = 1'b1;
			end
		end

		// registered decode flags follow the active instruction
		d.core  = (decode(d.ir) == jtc_pkg::CH_CORE);
		d.ext   = (decode(d.ir) == jtc_pkg::CH_EXT);
		d.intst = (decode(d.ir) == jtc_pkg::CH_INT);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// power-on reset forces the reset state; enable low leaves everything held
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= ST_RST;
		end else if (i_ce) begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign o_tdo      = q.tdo;
	assign o_tdo_oe_b = q.tdo_oe_b;
	assign o_bsc_upd  = q.bsc_upd;
	assign o_ir       = q.ir;
	assign o_core_sel = q.core;
	assign o_extest   = q.ext;
	assign o_intest   = q.intst;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	property p_hold;
		(i_ce && !rise && q.trst_s2) |=> $stable(q.state);
	endproperty
	a_hold: assert property (p_hold) else $error("tap state moved without a tck rise");

	property p_trst;
		(i_ce && !q.trst_s2) |=> (q.state == jtc_pkg::TS_RESET) && q.tdo_oe_b;
	endproperty
	a_trst: assert property (p_trst) else $error("test reset did not force reset state");

	property p_tlr_ir;
		(i_ce && q.state == jtc_pkg::TS_RESET) |=> (q.ir == jtc_pkg::IR_IDCODE);
	endproperty
	a_tlr_ir: assert property (p_tlr_ir) else $error("reset state without id instruction");

	property p_five;
		(q.tms_run >= jtc_pkg::TMS_RESET_RUN && q.trst_s2) |-> (q.state == jtc_pkg::TS_RESET);
	endproperty
	a_five: assert property (p_five) else $error("five tms highs did not reach reset");

	property p_oe;
		(i_ce && fall && q.state != jtc_pkg::TS_SH_IR && q.state != jtc_pkg::TS_SH_DR) |=> o_tdo_oe_b;
	endproperty
	a_oe: assert property (p_oe) else $error("tdo driven outside a shift state");

	property p_irupd;
		(i_ce && rise && q.trst_s2 && q.state == jtc_pkg::TS_UP_IR) |=> (q.ir == $past(q.ir_sh));
	endproperty
	a_irupd: assert property (p_irupd) else $error("update-ir did not load the instruction");

	property p_ext;
		(i_ce && (q.ext || q.intst)) |=> $stable(q.dr_sh) && $stable(q.bsc_upd);
	endproperty
	a_ext: assert property (p_ext) else $error("boundary test instruction touched a chain");

	property p_bypass;
		(i_ce && rise && q.trst_s2 && q.state == jtc_pkg::TS_CAP_DR && chain == jtc_pkg::CH_BYP)
			|=> (q.dr_sh[0] == 1'b0);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass capture not zero");

	property p_tdo_ir;
		(i_ce && fall && q.trst_s2 && q.state == jtc_pkg::TS_SH_IR) |=> !o_tdo_oe_b && (o_tdo == $past(q.ir_sh[0]));
	endproperty
	a_tdo_ir: assert property (p_tdo_ir) else $error("shift-ir output bit wrong");

	property p_core;
		(i_ce && fall && q.trst_s2 && q.state == jtc_pkg::TS_SH_DR && q.core) |=> (o_tdo == $past(q.ctdo_s2));
	endproperty
	a_core: assert property (p_core) else $error("core tap output not routed");

endmodule

`default_nettype wire

//--- tb/jtc_host_model.sv
// host model of the test port: drives tck, tms and tdi and samples the serial output
`timescale 1ns/100ps
`default_nettype none

module jtc_host_model (
	// pacing clock
	input  wire logic i_clk,
	// test port pins
	input  wire logic i_tdo,
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi
);
	// ----------------------------------------------------------------
	// pin sequencing
	// ----------------------------------------------------------------
	// idle levels match the pull-ups; tck stands high between frames
	initial begin
		o_tck = 1'b1;
		o_tms = 1'b1;
		o_tdi = 1'b1;
	end

	// one 320 ns tck period; tdo is read late in the high phase, where it is settled
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		@(posedge i_clk);
		o_tck <= 1'b0;
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (4) @(posedge i_clk);
		o_tck <= 1'b1;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		tdo = i_tdo;
	endtask

	// park the clock low; the next tick then carries no extra fall
	task automatic pause_low(input int n);
		@(posedge i_clk);
		o_tck <= 1'b0;
		repeat (n) @(posedge i_clk);
	endtask

	// from idle: capture, shift n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, 1'b0, b);
		if (ir) tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		tick(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		repeat (4) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the test access port controller
`timescale 1ns/100ps
`default_nettype none

module tb;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic                      i_clk      = 1'b0;
	logic                      i_rst_b    = 1'b0;
	logic                      i_trst_b   = 1'b1;
	logic                      ce         = 1'b1;
	logic                      i_core_tdo = 1'b0;
	logic [jtc_pkg::BSC_W-1:0] i_bsc_pins = '0;
	logic [jtc_pkg::BSC_W-1:0] bsc_exp    = '0;
	logic [15:0]               lfsr_q     = 16'hcc64; // seed 52324
	logic                      drove      = 1'b0;
	logic                      tck;
	logic                      tms;
	logic                      tdi;
	logic                      o_tdo;
	logic                      o_tdo_oe_b;
	logic                      o_core_sel;
	logic                      o_extest;
	logic                      o_intest;
	logic [jtc_pkg::BSC_W-1:0] o_bsc_upd;
	logic [jtc_pkg::IR_W-1:0]  o_ir;
	int                        errors     = 0;
	int                        num_checks = 0;
	// a released output reads as the pull-up level
	wire logic                 tdo_pin    = o_tdo_oe_b ? 1'b1 : o_tdo;

	always #20 i_clk = ~i_clk;

	// remember any drive of the serial output since the last clear
	always @(posedge i_clk) if (o_tdo_oe_b === 1'b0) drove <= 1'b1;

	jtc_tap dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_trst_b(i_trst_b), .i_tck(tck),
		.i_tms(tms), .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe_b(o_tdo_oe_b), .i_core_tdo(i_core_tdo),
		.i_bsc_pins(i_bsc_pins), .o_bsc_upd(o_bsc_upd), .o_ir(o_ir), .o_core_sel(o_core_sel),
		.o_extest(o_extest), .o_intest(o_intest));
	jtc_host_model host (.i_clk(i_clk), .i_tdo(tdo_pin), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// expected 32-bit data scan for an instruction, data in, pins and core level
	function automatic logic [31:0] exp_dr(input logic [3:0] c, input logic [31:0] d, input logic [7:0] p,
		input logic k);
		case (c)
			4'h0, 4'h1: return 32'hffff_ffff; // nothing drives, pull-up seen
			4'h2: return {d[23:0], p};
			4'he: return jtc_pkg::ID_VALUE;
			4'h8, 4'ha, 4'hb: return {32{k}};
			default: return {d[30:0], 1'b0}; // one bypass stage capturing 0
		endcase
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic go_idle;
		logic b;
		repeat (5) host.tick(1'b1, 1'b0, b);
		host.tick(1'b0, 1'b0, b);
	endtask

	// load one instruction, then push 32 random bits through the chain it selects
	task automatic run_code(input logic [3:0] c);
		logic [31:0] d;
		logic [31:0] q;
		logic        k;
		logic        pc;
		logic        b;
		lfsr_q = lfsr(lfsr_q);
		d[15:0] = lfsr_q;
		lfsr_q = lfsr(lfsr_q);
		d[31:16] = lfsr_q;
		k = lfsr_q[8];
		@(posedge i_clk);
		i_bsc_pins <= lfsr_q[7:0];
		i_core_tdo <= k;
		pc = o_core_sel;
		host.scan(1'b1, 4, {28'h0, c}, q);
		if (!pc) check("ir capture", q[3:0], 4'h1);
		check("active ir", o_ir, c);
		check("core select", o_core_sel, c inside {4'h8, 4'ha, 4'hb});
		check("extest", o_extest, c == 4'h0);
		check("intest", o_intest, c == 4'h1);
		// enable low: a whole tck period must be lost, else the data scan below goes astray
		if (c == 4'h2) begin
			ce <= 1'b0;
			host.tick(1'b1, 1'b0, b);
			host.pause_low(60);
			ce <= 1'b1;
			check("ir held", o_ir, c);
		end
		drove = 1'b0;
		host.scan(1'b0, 32, d, q);
		check("dr out", q, exp_dr(c, d, i_bsc_pins, k));
		check("tdo driven", drove, !(c inside {4'h0, 4'h1}));
		if (c == 4'h2) bsc_exp = d[31:24];
		check("boundary update", o_bsc_upd, bsc_exp);
		check("tdo released", o_tdo_oe_b, 1'b1);
		$display("code %h done", c);
	endtask

	initial begin
		repeat (90000) @(posedge i_clk);
		errors++;
		end_sim;
	end

	initial begin
		logic b;
		repeat (20) @(posedge i_clk);
		check("reset ir", o_ir, jtc_pkg::IR_IDCODE);
		check("reset oe", o_tdo_oe_b, 1'b1);
		check("reset upd", o_bsc_upd, 8'h00);
		i_rst_b <= 1'b1;
		repeat (5) @(posedge i_clk);
		go_idle;
		for (int c = 0; c < 16; c++) run_code(c[3:0]);
		repeat (4) begin
			lfsr_q = lfsr(lfsr_q);
			run_code(lfsr_q[3:0]);
		end
		$display("code sweep done");
		// five highs out of the middle of a data shift
		run_code(4'h2);
		host.tick(1'b1, 1'b0, b);
		host.tick(1'b0, 1'b0, b);
		host.tick(1'b0, 1'b0, b);
		repeat (5) host.tick(1'b1, 1'b0, b);
		repeat (4) @(posedge i_clk);
		check("tms reset ir", o_ir, jtc_pkg::IR_IDCODE);
		// the one shift on the way out moved a 0 in ahead of the captured pins
		bsc_exp = {1'b0, i_bsc_pins[jtc_pkg::BSC_W-1:1]};
		check("tms exit update", o_bsc_upd, bsc_exp);
		go_idle;
		// test reset low while tck keeps running
		run_code(4'h3);
		@(posedge i_clk);
		i_trst_b <= 1'b0;
		host.tick(1'b0, 1'b0, b);
		host.tick(1'b0, 1'b0, b);
		check("trst ir", o_ir, jtc_pkg::IR_IDCODE);
		check("trst oe", o_tdo_oe_b, 1'b1);
		@(posedge i_clk);
		i_trst_b <= 1'b1;
		go_idle;
		$display("reset paths done");
		// power-on reset in mid-run
		run_code(4'h2);
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (3) @(posedge i_clk);
		check("por ir", o_ir, jtc_pkg::IR_IDCODE);
		check("por upd", o_bsc_upd, 8'h00);
		bsc_exp = '0;
		i_rst_b <= 1'b1;
		repeat (5) @(posedge i_clk);
		go_idle;
		run_code(4'he);
		end_sim;
	end
endmodule
`default_nettype wire
